// ### hw/xmem_stretch.sv
// core timing, dual data pointers and stretched external data moves
// assumes classic wishbone master on clk_i, synchronous active high reset
`timescale 1ns/10ps
`include "xmem_stretch_defs.svh"
module xmem_stretch (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// port mode strap, high selects memory bus
	input wire logic xmem_en_i,
	// low address/data port
	input wire logic [7:0] lad_i,
	output logic [7:0] lad_o,
	output logic [7:0] lad_oe_o,
	// high address port
	input wire logic [7:0] had_i,
	output logic [7:0] had_o,
	output logic [7:0] had_oe_o,
	// strobes and latch enable
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ale_o
);
	logic [7:0] clock_and_stretch_control_q;
	logic [15:0] data_pointer_register_q [2];
	logic dpsel_q;
	logic [7:0] wdat_q, rdat_q;
	logic [7:0] gpio_lo_q, gpio_hi_q, gdir_lo_q, gdir_hi_q;
	logic [15:0] tmr_q;
	logic wr_q, busy_q;
	xmem_stretch_pkg::xm_state_e st_q;
	logic [5:0] cnt_q;
	logic [2:0] md;
	logic [4:0] strobe_len;
	logic [5:0] total_clk;
	logic icyc_end, tmr_tick, xmem_mode;
	logic [7:0] lad_s, had_s;
	logic acc, wr_acc, go;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////
	// leaf instances
	icycle_gen u_icyc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fast_tmr_i(clock_and_stretch_control_q[`CKS_T4_BIT]),
		.icyc_end_o(icyc_end),
		.tmr_tick_o(tmr_tick)
	);
	sync3 #(.W(16)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({had_i, lad_i}),
		.q_o({had_s, lad_s})
	);

	// strap sampled at reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xmem_mode <= xmem_en_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus decode
	assign acc = cyc_i && stb_i && !ack_o;
	assign wr_acc = acc && we_i && sel_i[0];
	assign go = wr_acc && adr_i == `ADR_XCMD && !busy_q && xmem_mode;
	assign md = clock_and_stretch_control_q[`CKS_MD_MSB:`CKS_MD_LSB];
	// strobe clocks from stretch code
	assign strobe_len = (md == 3'd0) ? `STROBE_MIN : {md, 2'b00};
	// total move length in clocks, code plus two cycles
	assign total_clk = {1'b0, ({2'b00, md} + 5'd2)} * 6'(`CLK_PER_ICYC);

	// single cycle ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= acc;
		end
	end

	// control register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_and_stretch_control_q <= `CKS_RESET;
			dpsel_q <= 1'b0;
			wdat_q <= 8'h00;
			gpio_lo_q <= 8'h00;
			gpio_hi_q <= 8'h00;
			gdir_lo_q <= 8'h00;
			gdir_hi_q <= 8'h00;
		end else if (wr_acc) begin
			unique case (adr_i)
				`ADR_CLK_STRETCH: clock_and_stretch_control_q <= dat_i[7:0];
				`ADR_DPSEL: dpsel_q <= dat_i[0];
				`ADR_XDATA: begin
					wdat_q <= dat_i[7:0];
					if (sel_i[1]) gpio_lo_q <= dat_i[15:8];
					if (sel_i[2]) gpio_hi_q <= dat_i[23:16];
				end
				`ADR_STATUS: begin
					gdir_lo_q <= dat_i[7:0];
					if (sel_i[1]) gdir_hi_q <= dat_i[15:8];
				end
				default: ;
			endcase
		end
	end

	// two pointers, pre increment as a move starts, before the address goes out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_pointer_register_q[0] <= 16'h0000;
			data_pointer_register_q[1] <= 16'h0000;
		end else if (wr_acc && adr_i == `ADR_DPTR0 && sel_i[1:0] == 2'b11) begin
			data_pointer_register_q[0] <= dat_i[15:0];
		end else if (wr_acc && adr_i == `ADR_DPTR1 && sel_i[1:0] == 2'b11) begin
			data_pointer_register_q[1] <= dat_i[15:0];
		end else if (go && dat_i[`XCMD_INC_BIT]) begin
			data_pointer_register_q[dpsel_q] <= data_pointer_register_q[dpsel_q] + 16'h0001;
		end
	end

	// timer counts prescaled ticks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmr_q <= 16'h0000;
		end else if (tmr_tick) begin
			tmr_q <= tmr_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// external move sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= xmem_stretch_pkg::XM_IDLE;
			cnt_q <= 6'd0;
			busy_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			unique case (st_q)
				xmem_stretch_pkg::XM_IDLE: begin
					if (go) begin
						st_q <= xmem_stretch_pkg::XM_ADDR;
						wr_q <= dat_i[`XCMD_WR_BIT];
						busy_q <= 1'b1;
						cnt_q <= 6'd1;
					end
				end
				xmem_stretch_pkg::XM_ADDR: begin
					cnt_q <= cnt_q + 6'd1;
					if (cnt_q == 6'd2) begin
						st_q <= xmem_stretch_pkg::XM_STRB;
					end
				end
				xmem_stretch_pkg::XM_STRB: begin
					cnt_q <= cnt_q + 6'd1;
					if (cnt_q == 6'd2 + {1'b0, strobe_len}) begin
						st_q <= xmem_stretch_pkg::XM_TAIL;
					end
				end
				xmem_stretch_pkg::XM_TAIL: begin
					cnt_q <= cnt_q + 6'd1;
					if (cnt_q >= total_clk) begin
						st_q <= xmem_stretch_pkg::XM_IDLE;
						busy_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// instruction cycles spent in the current move, for the length check
	logic [3:0] icnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || go) begin
			icnt_q <= 4'd0;
		end else if (busy_q && icyc_end) begin
			icnt_q <= icnt_q + 4'd1;
		end
	end

	// read data caught four clocks after strobe end: by then the pin
	// samples of the last two strobe clocks have crossed the synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 8'h00;
		end else if (st_q == xmem_stretch_pkg::XM_TAIL && !wr_q &&
			cnt_q == 6'd6 + {1'b0, strobe_len}) begin
			rdat_q <= lad_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drivers, registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lad_o <= 8'h00;
			lad_oe_o <= 8'h00;
			had_o <= 8'h00;
			had_oe_o <= 8'h00;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			ale_o <= 1'b0;
		end else if (xmem_mode) begin
			had_o <= data_pointer_register_q[dpsel_q][15:8];
			had_oe_o <= 8'hFF;
			ale_o <= (st_q == xmem_stretch_pkg::XM_ADDR);
			if (st_q == xmem_stretch_pkg::XM_ADDR) begin
				lad_o <= data_pointer_register_q[dpsel_q][7:0];
				lad_oe_o <= 8'hFF;
			end else begin
				lad_o <= wdat_q;
				lad_oe_o <= {8{wr_q && st_q != xmem_stretch_pkg::XM_IDLE}};
			end
			rd_n_o <= !(st_q == xmem_stretch_pkg::XM_STRB && !wr_q);
			wr_n_o <= !(st_q == xmem_stretch_pkg::XM_STRB && wr_q);
		end else begin
			lad_o <= gpio_lo_q;
			lad_oe_o <= gdir_lo_q;
			had_o <= gpio_hi_q;
			had_oe_o <= gdir_hi_q;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			ale_o <= 1'b0;
		end
	end

	// read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (adr_i)
			`ADR_CLK_STRETCH: rd_mux = {24'h00_0000, clock_and_stretch_control_q};
			`ADR_DPTR0: rd_mux = {16'h0000, data_pointer_register_q[0]};
			`ADR_DPTR1: rd_mux = {16'h0000, data_pointer_register_q[1]};
			`ADR_DPSEL: rd_mux = {24'h00_0000, 7'h00, dpsel_q};
			`ADR_XDATA: rd_mux = {had_s, lad_s, 8'h00, rdat_q};
			`ADR_STATUS: rd_mux = {8'h00, 6'h00, xmem_mode, busy_q, gdir_hi_q, gdir_lo_q};
			`ADR_TIMER: rd_mux = {16'h0000, tmr_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else begin
			dat_o <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_rd_code0;
		@(posedge clk_i) disable iff (rst_i)
		($fell(rd_n_o) && md == 3'd0) |-> !rd_n_o [*2] ##1 rd_n_o;
	endproperty
	a_rd_code0: assert property (p_rd_code0) else $error("read strobe not 2");
	property p_wr_code1;
		@(posedge clk_i) disable iff (rst_i)
		($fell(wr_n_o) && md == 3'd1) |-> !wr_n_o [*4] ##1 wr_n_o;
	endproperty
	a_wr_code1: assert property (p_wr_code1) else $error("write strobe not 4");
	property p_strobe_excl;
		@(posedge clk_i) disable iff (rst_i) !( !rd_n_o && !wr_n_o);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes");
	sequence s_start;
		go && md == 3'd1;
	endsequence
	property p_len;
		@(posedge clk_i) disable iff (rst_i)
		s_start |=> busy_q [*8] ##1 busy_q [*4] ##1 !busy_q;
	endproperty
	a_len: assert property (p_len) else $error("move not 12 clocks");
	property p_icyc;
		@(posedge clk_i) disable iff (rst_i)
		$fell(busy_q) |-> icnt_q == {1'b0, md} + 4'd2;
	endproperty
	a_icyc: assert property (p_icyc) else $error("move not code plus two cycles");
	property p_ale;
		@(posedge clk_i) disable iff (rst_i) $rose(ale_o) |-> lad_oe_o == 8'hFF;
	endproperty
	a_ale: assert property (p_ale) else $error("address not driven");
	property p_gpio;
		@(posedge clk_i) disable iff (rst_i) !xmem_mode |=> rd_n_o && wr_n_o && !ale_o;
	endproperty
	a_gpio: assert property (p_gpio) else $error("strobe in gpio mode");
	property p_ack;
		@(posedge clk_i) disable iff (rst_i) (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_tmr;
		@(posedge clk_i) disable iff (rst_i)
		(tmr_tick && !clock_and_stretch_control_q[`CKS_T4_BIT]) |=>
			!(tmr_tick && !clock_and_stretch_control_q[`CKS_T4_BIT]) [*8];
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer too fast");
endmodule

// ### hw/xmem_stretch_defs.svh
// constants for the core timing and external data move block
// assumes inclusion by bare name from design files
`ifndef XMEM_STRETCH_DEFS_SVH
`define XMEM_STRETCH_DEFS_SVH
// register byte addresses; control sits off the word grid, byte lane 0
`define ADR_CLK_STRETCH 8'h8E
`define ADR_DPTR0 8'h90
`define ADR_DPTR1 8'h94
`define ADR_DPSEL 8'h98
`define ADR_XCMD 8'h9C
`define ADR_XDATA 8'hA0
`define ADR_STATUS 8'hA4
`define ADR_TIMER 8'hA8
// clock and stretch control fields
`define CKS_MD_LSB 0
`define CKS_MD_MSB 2
`define CKS_T4_BIT 3
`define CKS_RESET 8'h01
// command register fields
`define XCMD_WR_BIT 0
`define XCMD_INC_BIT 1
// timing counts in system clocks
`define CLK_PER_ICYC 3'd4
`define TMR_DIV_SLOW 4'd12
`define TMR_DIV_FAST 4'd4
`define STROBE_MIN 5'd2
`endif

// ### hw/xmem_stretch_pkg.sv
// types for the external data move block
// assumes nothing beyond the defs header
package xmem_stretch_pkg;
	typedef enum logic [3:0] {
		XM_IDLE = 4'b0001,
		XM_ADDR = 4'b0010,
		XM_STRB = 4'b0100,
		XM_TAIL = 4'b1000
	} xm_state_e;
endpackage

// ### hw/icycle_gen.sv
// instruction cycle phase counter and timer tick generator
// assumes one system clock, synchronous reset
`timescale 1ns/10ps
`include "xmem_stretch_defs.svh"
module icycle_gen (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// config
	input wire logic fast_tmr_i,
	// outputs
	output logic icyc_end_o,
	output logic tmr_tick_o
);
	logic [1:0] ph_q;
	logic [3:0] div_q;
	logic [3:0] lim;

	// four clock instruction cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= 2'd0;
		end else begin
			ph_q <= ph_q + 2'd1;
		end
	end
	assign icyc_end_o = (ph_q == 2'd3);

	// timer prescale of 12 or 4 clocks
	assign lim = fast_tmr_i ? `TMR_DIV_FAST : `TMR_DIV_SLOW;
	always_ff @(posedge clk_i) begin
		if (rst_i || div_q >= lim - 4'd1) begin
			div_q <= 4'd0;
		end else begin
			div_q <= div_q + 4'd1;
		end
	end
	assign tmr_tick_o = !rst_i && (div_q >= lim - 4'd1);

	property p_ph;
		@(posedge clk_i) disable iff (rst_i)
		icyc_end_o |=> !icyc_end_o [*3] ##1 icyc_end_o;
	endproperty
	a_ph: assert property (p_ph) else $error("cycle not 4");
endmodule

// ### hw/sync3.sv
// three stage pin synchroniser with agreement filter
// assumes asynchronous input, one clock
`timescale 1ns/10ps
module sync3 #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_q, s2_q, s3_q;

	// refuse an empty synchroniser
	if (W < 1) begin : g_w_check
		$error("sync3 width below one");
	end

	// shift chain; first stage read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_o <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					q_o[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// ### sim/xmem_partner.sv
// behavioural external data memory on the multiplexed bus
// assumes resolved pin levels from the bench, one clock
`timescale 1ns/10ps
module xmem_partner (
	// clock
	input wire logic clk_i,
	// bus from the block
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] lad_i,
	input wire logic [7:0] had_i,
	// data driven back
	output logic [7:0] lad_o
);
	logic [7:0] mem [0:65535];
	logic [15:0] adr_q;
	logic [7:0] last_q;

	////////////////////////////////////////////////////////////////
	// latch address, store writes, track last pin level
	always @(posedge clk_i) begin
		last_q <= lad_i;
		if (ale_i) adr_q <= {had_i, lad_i};
		if (!wr_n_i) mem[adr_q] <= lad_i;
	end
	// answer at once on read strobe, else inverse of last level
	assign lad_o = !rd_n_i ? mem[adr_q] : ~last_q;
endmodule

// ### sim/xmem_stretch_tb.sv
// bench for stretched external data moves, pointers, timer and gpio mode
// assumes the memory model on the far side and a 50 ns clock
`timescale 1ns/10ps
`include "xmem_stretch_defs.svh"
module xmem_stretch_tb;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, xmem_en_i = 1;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, q, t0;
	logic ack_o, rd_n_o, wr_n_o, ale_o;
	logic [7:0] lad_o, lad_oe_o, had_o, had_oe_o, p_lad;
	logic [15:0] seen_adr;
	int n_mismatch = 0, samples_checked = 0, cyc_n = 0, wid = 0, w_q = 0, c0, d;
	wire logic [7:0] lad_pin = (lad_oe_o & lad_o) | (~lad_oe_o & p_lad);
	wire logic [7:0] had_pin = (had_oe_o & had_o) | (~had_oe_o & 8'h3c);

	xmem_stretch xmem_stretch_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .xmem_en_i(xmem_en_i), .lad_i(lad_pin),
		.lad_o(lad_o), .lad_oe_o(lad_oe_o), .had_i(had_pin), .had_o(had_o),
		.had_oe_o(had_oe_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ale_o(ale_o));
	xmem_partner xmem_partner_i (.clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
		.wr_n_i(wr_n_o), .lad_i(lad_pin), .had_i(had_pin), .lad_o(p_lad));

	////////////////////////////////////////////////////////////////
	// clock, strobe width and address monitor, timeout
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		w_q <= (!rd_n_o || !wr_n_o) ? w_q + 1 : 0;
		if (rd_n_o && wr_n_o && w_q != 0) wid <= w_q;
		if (ale_o) seen_adr <= {had_o, lad_o};
		if (cyc_n == 20000) begin
			n_mismatch++;
			test_done;
		end
	end

	////////////////////////////////////////////////////////////////
	// compare, bus cycle, reset and wait helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d_w);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d_w;
		sel_i <= 4'hf;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50) begin
			n_mismatch++;
			test_done;
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic do_reset(input logic en);
		xmem_en_i <= en;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		wb(0, `ADR_STATUS, 0);
		while (q[16] !== 1'b0 && n < 40) begin
			wb(0, `ADR_STATUS, 0);
			n++;
		end
		if (n == 40) begin
			n_mismatch++;
			test_done;
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		do_reset(1'b1);
		wb(0, `ADR_CLK_STRETCH, 0);
		chk({24'h0, q[7:0]}, 32'h0000_0001);
		wb(1, `ADR_DPTR0, 32'h0000_1234);
		wb(1, `ADR_DPTR1, 32'h0000_beef);
		wb(0, `ADR_DPTR0, 0);
		chk(q & 32'h0000_ffff, 32'h0000_1234);
		wb(0, `ADR_DPTR1, 0);
		chk(q & 32'h0000_ffff, 32'h0000_beef);
		wb(0, 8'hfc, 0);
		chk(q, 32'h0000_0000);
		$display("test registers done");
		// write then read back through the other pointer, every code
		for (int c = 0; c < 8; c++) begin
			wb(1, `ADR_CLK_STRETCH, 32'(c));
			wb(1, `ADR_DPSEL, 0);
			wb(1, `ADR_DPTR0, 32'h0000_1200 + 32'(c));
			wb(1, `ADR_XDATA, 32'h0000_0040 + 32'(c));
			wb(1, `ADR_XCMD, 32'h0000_0001);
			wb(0, `ADR_STATUS, 0);
			chk(32'(q[16]), 32'h0000_0001);
			wait_idle;
			chk(32'(wid), c == 0 ? 32'h0000_0002 : 32'(4 * c));
			chk({16'h0, seen_adr}, 32'h0000_1200 + 32'(c));
			wb(1, `ADR_DPTR1, 32'h0000_1200 + 32'(c));
			wb(1, `ADR_DPSEL, 1);
			wb(1, `ADR_XCMD, 0);
			wait_idle;
			chk(32'(wid), c == 0 ? 32'h0000_0002 : 32'(4 * c));
			wb(0, `ADR_XDATA, 0);
			chk({24'h0, q[7:0]}, 32'h0000_0040 + 32'(c));
		end
		// write with pre increment: selected pointer steps first, other stays
		wb(1, `ADR_XCMD, 32'h0000_0003);
		wait_idle;
		chk({16'h0, seen_adr}, 32'h0000_1208);
		wb(0, `ADR_DPTR1, 0);
		chk(q & 32'h0000_ffff, 32'h0000_1208);
		wb(0, `ADR_DPTR0, 0);
		chk(q & 32'h0000_ffff, 32'h0000_1207);
		$display("test moves done");
		// two timer reads exactly 48 clocks apart, slow then fast
		for (int f = 0; f < 2; f++) begin
			wb(1, `ADR_CLK_STRETCH, f ? 32'h0000_0009 : 32'h0000_0001);
			c0 = cyc_n;
			wb(0, `ADR_TIMER, 0);
			d = cyc_n - c0;
			t0 = q;
			repeat (48 - d) @(posedge clk_i);
			wb(0, `ADR_TIMER, 0);
			chk(q - t0, f ? 32'h0000_000c : 32'h0000_0004);
		end
		$display("test timer done");
		// general purpose mode: outputs, pin readback, moves refused
		do_reset(1'b0);
		wb(0, `ADR_STATUS, 0);
		chk(32'(q[17]), 32'h0000_0000);
		wb(1, `ADR_STATUS, 32'h0000_ffff);
		wb(1, `ADR_XDATA, 32'h005a_a500);
		chk({had_oe_o, had_o, lad_oe_o, lad_o}, 32'hff5a_ffa5);
		wb(1, `ADR_XCMD, 32'h0000_0001);
		wb(0, `ADR_STATUS, 0);
		chk(32'(q[16]), 32'h0000_0000);
		chk({30'h0, rd_n_o, wr_n_o}, 32'h0000_0003);
		wb(0, `ADR_XDATA, 0);
		chk(q & 32'hffff_0000, 32'h5aa5_0000);
		$display("test gpio done");
		test_done;
	end
endmodule
